// ### core/gain_loop_control.sv
// Purpose: gain loop configuration register and the loop it steers
// Assumes: all inputs come from logic on clk_in
// Notes: gain values are reduction indices, 0 is the highest gain
//
// Function
// - two-bit hysteresis select, reset 2, sets the deviation dead zone
// - after a gain step skip 8, 16, 24 or 32 samples; reset 16
// - hold policy 0 (reset) adjusts freely; 1 holds gain after sync
// - policy 2 holds analog gain only; policy 3 holds both gains
// - filter field: averaging 8..64 samples, or OOK boundary 4..16 dB
// - loop steers averaged amplitude toward the target, 1 LSB is 1 dB
`timescale 1ns/10ps
`include "gain_loop_cfg.svh"
module gain_loop_control #(
   parameter int AMP_W = 8
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [`GLC_ADDR_W-1:0] addr_in,
   input wire logic wr_en_in,
   input wire logic [7:0] wr_data_in,
   input wire logic rd_en_in,
   output logic [7:0] rd_data_out,
   output logic rd_valid_out,
   input wire logic sample_valid_in,
   input wire logic [AMP_W-1:0] amplitude_in,
   input wire logic [2:0] amplitude_goal_in,
   input wire logic ook_mode_in,
   input wire logic sync_found_in,
   input wire logic rx_restart_in,
   output logic [1:0] deviation_hysteresis_sel_out,
   output logic [4:0] ook_boundary_db_out,
   output logic [2:0] analog_gain_out,
   output logic [2:0] digital_gain_out,
   output logic gain_step_out
);
   localparam int SUM_W = AMP_W + 6;
   localparam int DEV_W = AMP_W + 2;

   // sum and deviation widths only serve this amplitude range
   if (AMP_W < 6 || AMP_W > 24) begin
      $error("AMP_W out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // register access
   logic [7:0] cfg_r, cfg_nxt;
   logic [7:0] rd_data_r, rd_data_nxt;
   logic rd_valid_r, rd_valid_nxt;
   logic hit;
   logic [4:0] ook_db_r, ook_db_nxt;

   always_comb begin
      hit = (addr_in == `GLC_OFFSET);
      cfg_nxt = cfg_r;
      if (wr_en_in && hit) begin
         cfg_nxt = wr_data_in;
      end
      rd_valid_nxt = rd_en_in;
      rd_data_nxt = (rd_en_in && hit) ? cfg_r : 8'h00;
      ook_db_nxt = 5'({cfg_r[`GLC_FILT_MSB:`GLC_FILT_LSB], 2'h0})
         + 5'(`GLC_OOK_STEP_DB * 2);
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cfg_r <= `GLC_RESET;
         rd_data_r <= 8'h00;
         rd_valid_r <= 1'b0;
         ook_db_r <= `GLC_OOK_RESET;
      end else begin
         cfg_r <= cfg_nxt;
         rd_data_r <= rd_data_nxt;
         rd_valid_r <= rd_valid_nxt;
         ook_db_r <= ook_db_nxt;
      end
   end

   assign rd_data_out = rd_data_r;
   assign rd_valid_out = rd_valid_r;
   assign deviation_hysteresis_sel_out = cfg_r[`GLC_HYST_MSB:`GLC_HYST_LSB];
   assign ook_boundary_db_out = ook_db_r;

   ////////////////////////////////////////////////////////////////////////
   // gain loop
   gain_loop_pkg::loop_state_t state_r, state_nxt;
   gain_loop_pkg::hold_policy_t policy;
   logic [6:0] cnt_r, cnt_nxt;
   logic [SUM_W-1:0] sum_r, sum_nxt, total;
   logic held_r, held_nxt;
   logic [2:0] again_r, again_nxt, dgain_r, dgain_nxt;
   logic step_r, step_nxt;
   logic [1:0] avg_sel, wait_sel;
   logic [6:0] avg_len, wait_len;
   logic [AMP_W-1:0] avg;
   logic [5:0] target_db;
   logic [2:0] dz_lo, dz_hi;
   logic signed [DEV_W-1:0] dev;
   logic want_dn, want_up, a_hold, d_hold;

   always_comb begin
      policy = gain_loop_pkg::hold_policy_t'(
         cfg_r[`GLC_HOLD_MSB:`GLC_HOLD_LSB]);
      wait_sel = cfg_r[`GLC_WAIT_MSB:`GLC_WAIT_LSB];
      wait_len = 7'({wait_sel, 3'h0}) + 7'(1 << `GLC_WAIT_UNIT);
      avg_sel = ook_mode_in ? `GLC_OOK_AVG_SEL
                            : cfg_r[`GLC_FILT_MSB:`GLC_FILT_LSB];
      // shift amount needs three bits, two would wrap at 4
      avg_len = 7'(7'h01 << (3'(avg_sel) + 3'(`GLC_FILT_BASE)));
      total = sum_r + SUM_W'(amplitude_in);
      avg = AMP_W'(total >> (3'(avg_sel) + 3'(`GLC_FILT_BASE)));
      case (amplitude_goal_in)
         3'h0: target_db = 6'h18;
         3'h1: target_db = 6'h1B;
         3'h2: target_db = 6'h1E;
         3'h3: target_db = 6'h21;
         3'h4: target_db = 6'h24;
         3'h5: target_db = 6'h26;
         3'h6: target_db = 6'h28;
         default: target_db = 6'h2A;
      endcase
      case (cfg_r[`GLC_HYST_MSB:`GLC_HYST_LSB])
         2'h0: begin
            dz_lo = 3'h1;
            dz_hi = 3'h1;
         end
         2'h1: begin
            dz_lo = 3'h2;
            dz_hi = 3'h1;
         end
         2'h2: begin
            dz_lo = 3'h4;
            dz_hi = 3'h2;
         end
         default: begin
            dz_lo = 3'h6;
            dz_hi = 3'h3;
         end
      endcase
      dev = $signed(DEV_W'(avg)) - $signed(DEV_W'(target_db));
      want_dn = dev > $signed(DEV_W'(dz_hi));
      want_up = dev < -$signed(DEV_W'(dz_lo));
      a_hold = (policy == gain_loop_pkg::HOLD_ANALOG)
         || (policy == gain_loop_pkg::HOLD_ALL)
         || (policy == gain_loop_pkg::HOLD_ON_SYNC && held_r);
      d_hold = (policy == gain_loop_pkg::HOLD_ALL)
         || (policy == gain_loop_pkg::HOLD_ON_SYNC && held_r);

      held_nxt = held_r;
      if (rx_restart_in) begin
         held_nxt = 1'b0;
      end
      if (sync_found_in) begin
         held_nxt = 1'b1;
      end
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      sum_nxt = sum_r;
      again_nxt = again_r;
      dgain_nxt = dgain_r;
      step_nxt = 1'b0;
      case (state_r)
         gain_loop_pkg::ST_SETTLE: begin
            if (sample_valid_in) begin
               cnt_nxt = cnt_r + 7'h01;
               if (cnt_r + 7'h01 >= wait_len) begin
                  state_nxt = gain_loop_pkg::ST_ACCUM;
                  cnt_nxt = 7'h00;
                  sum_nxt = '0;
               end
            end
         end
         gain_loop_pkg::ST_ACCUM: begin
            if (sample_valid_in) begin
               cnt_nxt = cnt_r + 7'h01;
               sum_nxt = total;
               if (cnt_r + 7'h01 >= avg_len) begin
                  cnt_nxt = 7'h00;
                  sum_nxt = '0;
                  if (want_dn && !a_hold && again_r != `GLC_GAIN_MAX) begin
                     again_nxt = again_r + 3'h1;
                     step_nxt = 1'b1;
                  end else if (want_dn && !d_hold
                               && dgain_r != `GLC_GAIN_MAX) begin
                     dgain_nxt = dgain_r + 3'h1;
                     step_nxt = 1'b1;
                  end else if (want_up && !d_hold && dgain_r != 3'h0) begin
                     dgain_nxt = dgain_r - 3'h1;
                     step_nxt = 1'b1;
                  end else if (want_up && !a_hold && again_r != 3'h0) begin
                     again_nxt = again_r - 3'h1;
                     step_nxt = 1'b1;
                  end
                  if (step_nxt) begin
                     state_nxt = gain_loop_pkg::ST_SETTLE;
                  end
               end
            end
         end
         default: state_nxt = gain_loop_pkg::ST_ACCUM;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_r <= gain_loop_pkg::ST_ACCUM;
         cnt_r <= 7'h00;
         sum_r <= '0;
         held_r <= 1'b0;
         again_r <= 3'h0;
         dgain_r <= 3'h0;
         step_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         sum_r <= sum_nxt;
         held_r <= held_nxt;
         again_r <= again_nxt;
         dgain_r <= dgain_nxt;
         step_r <= step_nxt;
      end
   end

   assign analog_gain_out = again_r;
   assign digital_gain_out = dgain_r;
   assign gain_step_out = step_r;

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   a_hyst_stable: assert property (
      !(wr_en_in && hit) |=> $stable(deviation_hysteresis_sel_out))
      else $error("hysteresis select changed without a write");
   a_settle_quiet: assert property (
      $rose(step_r) |=> !step_r [*8])
      else $error("gain stepped again inside settle wait");
   a_sync_hold: assert property (
      policy == gain_loop_pkg::HOLD_ON_SYNC && held_r && !rx_restart_in
      |=> $stable(again_r) && $stable(dgain_r))
      else $error("gain moved after sync under hold on sync");
   a_manual_hold: assert property (
      policy == gain_loop_pkg::HOLD_ANALOG
      || policy == gain_loop_pkg::HOLD_ALL |=> $stable(again_r))
      else $error("analog gain moved under manual hold");
   a_ook_bound: assert property (
      ##1 ook_boundary_db_out ==
      5'({$past(cfg_r[`GLC_FILT_MSB:`GLC_FILT_LSB]), 2'h0}) + 5'h04)
      else $error("ook boundary does not follow filter field");
   a_step_dir: assert property (
      again_nxt > again_r |-> dev > 0)
      else $error("gain reduced while below target");
   a_write_read: assert property (
      wr_en_in && hit ##1 rd_en_in && hit && !wr_en_in
      |=> rd_data_out == $past(wr_data_in, 2))
      else $error("read does not return written value");

   c_step: cover property ($rose(step_r));
   c_sync_hold: cover property (
      policy == gain_loop_pkg::HOLD_ON_SYNC && $rose(held_r));
   c_ook_eval: cover property (ook_mode_in && step_r);
endmodule

// ### pkg/gain_loop_cfg.svh
// Purpose: constants for the gain loop configuration register
// Assumes: 8-bit register at a 6-bit address
// Notes: settle and averaging lengths are in channel filter samples
`ifndef GAIN_LOOP_CFG_SVH
`define GAIN_LOOP_CFG_SVH
`define GLC_ADDR_W 6
`define GLC_OFFSET 6'h1D
`define GLC_RESET 8'h91
`define GLC_HYST_MSB 7
`define GLC_HYST_LSB 6
`define GLC_WAIT_MSB 5
`define GLC_WAIT_LSB 4
`define GLC_HOLD_MSB 3
`define GLC_HOLD_LSB 2
`define GLC_FILT_MSB 1
`define GLC_FILT_LSB 0
`define GLC_WAIT_UNIT 3
`define GLC_FILT_BASE 3
`define GLC_OOK_STEP_DB 2
`define GLC_OOK_AVG_SEL 2'h0
`define GLC_OOK_RESET 5'h08
`define GLC_GAIN_MAX 3'h7
`endif

// ### pkg/gain_loop_pkg.sv
// Purpose: types for the gain loop configuration block
// Assumes: nothing
// Notes: none
package gain_loop_pkg;
   typedef enum logic [1:0] {
      HOLD_NONE,
      HOLD_ON_SYNC,
      HOLD_ANALOG,
      HOLD_ALL
   } hold_policy_t;
   typedef enum logic {
      ST_SETTLE,
      ST_ACCUM
   } loop_state_t;
endpackage

// ### verif/tb.sv
// Purpose: self-checking bench for the gain loop configuration block
// Assumes: register at 0x1D, reset 0x91; dead zones as in the design
// Notes: integer model of the loop is compared after every sample
`timescale 1ns/10ps
`include "gain_loop_cfg.svh"
module tb;
   logic clk_in = 0, rst_in = 1, wr_en_in = 0, rd_en_in = 0;
   logic sample_valid_in = 0, ook_mode_in = 0;
   logic sync_found_in = 0, rx_restart_in = 0, rd_valid_out, gain_step_out;
   logic [5:0] addr_in = '0;
   logic [7:0] wr_data_in = '0, amplitude_in = '0, rd_data_out;
   logic [7:0] cfg, steps_seen = '0;
   logic [2:0] amplitude_goal_in = '0, analog_gain_out, digital_gain_out;
   logic [1:0] deviation_hysteresis_sel_out;
   logic [4:0] ook_boundary_db_out;
   int fail_count = 0, check_count = 0;
   int m_acc, m_cnt, m_settle, m_an, m_dg, m_sync, steps_exp, lvl;
   int goals[8] = '{24, 27, 30, 33, 36, 38, 40, 42};
   int lo_dz[4] = '{1, 2, 4, 6};
   int hi_dz[4] = '{1, 1, 2, 3};
   gain_loop_control dut (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .addr_in(addr_in),
      .wr_en_in(wr_en_in),
      .wr_data_in(wr_data_in),
      .rd_en_in(rd_en_in),
      .rd_data_out(rd_data_out),
      .rd_valid_out(rd_valid_out),
      .sample_valid_in(sample_valid_in),
      .amplitude_in(amplitude_in),
      .amplitude_goal_in(amplitude_goal_in),
      .ook_mode_in(ook_mode_in),
      .sync_found_in(sync_found_in),
      .rx_restart_in(rx_restart_in),
      .deviation_hysteresis_sel_out(deviation_hysteresis_sel_out),
      .ook_boundary_db_out(ook_boundary_db_out),
      .analog_gain_out(analog_gain_out),
      .digital_gain_out(digital_gain_out),
      .gain_step_out(gain_step_out)
   );
   initial forever #4 clk_in = ~clk_in;
   always @(posedge clk_in) if (gain_step_out === 1'b1) steps_seen++;
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [7:0] s, e);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // write then read back in the very next cycle
   task automatic reg_wr_rd(input logic [7:0] d);
      @(posedge clk_in) addr_in <= `GLC_OFFSET;
      wr_data_in <= d;
      wr_en_in <= 1;
      @(posedge clk_in) wr_en_in <= 0;
      rd_en_in <= 1;
      @(posedge clk_in) rd_en_in <= 0;
      #1 check("rd_valid", {7'h0, rd_valid_out}, 8'h01);
      check("rd_data", rd_data_out, d);
   endtask
   task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_in) addr_in <= a;
      wr_data_in <= d;
      wr_en_in <= 1;
      @(posedge clk_in) wr_en_in <= 0;
   endtask
   task automatic reg_rd(input logic [5:0] a, input logic [7:0] e);
      @(posedge clk_in) addr_in <= a;
      rd_en_in <= 1;
      @(posedge clk_in) rd_en_in <= 0;
      #1 check("rd_valid", {7'h0, rd_valid_out}, 8'h01);
      check("rd_data", rd_data_out, e);
   endtask
   // one sample through the design and the model, then compare
   task automatic sample(input int a);
      int n, sh, dv, hs, ha, hd, st;
      a = a < 0 ? 0 : (a > 255 ? 255 : a);
      @(posedge clk_in) sample_valid_in <= 1;
      amplitude_in <= a[7:0];
      @(posedge clk_in) sample_valid_in <= 0;
      repeat (3) @(posedge clk_in);
      sh = ook_mode_in ? 3 : 3 + cfg[1:0];
      n = 1 << sh;
      hs = cfg[3:2];
      if (m_settle > 0) m_settle--;
      else begin
         m_acc += a;
         m_cnt++;
         if (m_cnt == n) begin
            dv = (m_acc >> sh) - goals[amplitude_goal_in];
            ha = hs >= 2 || (hs == 1 && m_sync);
            hd = hs == 3 || (hs == 1 && m_sync);
            st = 1;
            if (dv > hi_dz[cfg[7:6]]) begin
               if (!ha && m_an < 7) m_an++;
               else if (!hd && m_dg < 7) m_dg++;
               else st = 0;
            end else if (dv < -lo_dz[cfg[7:6]]) begin
               if (!hd && m_dg > 0) m_dg--;
               else if (!ha && m_an > 0) m_an--;
               else st = 0;
            end else st = 0;
            if (st) begin
               steps_exp++;
               m_settle = (cfg[5:4] + 1) * 8;
            end
            m_acc = 0;
            m_cnt = 0;
         end
      end
      check("steps", steps_seen, steps_exp[7:0]);
      check("analog", {5'h0, analog_gain_out}, m_an[7:0]);
      check("digital", {5'h0, digital_gain_out}, m_dg[7:0]);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #400000;
      fail_count++;
      end_sim();
   end
   initial begin
      void'($urandom(47));
      {m_acc, m_cnt, m_settle, m_an, m_dg, m_sync, steps_exp} = '0;
      cfg = `GLC_RESET;
      repeat (3) @(posedge clk_in);
      rst_in <= 0;
      reg_rd(6'h1D, 8'h91);
      check("hyst", {6'h0, deviation_hysteresis_sel_out}, 8'h02);
      check("ook", {3'h0, ook_boundary_db_out}, 8'h08);
      reg_wr(6'h1E, 8'h3C);
      reg_rd(6'h1E, 8'h00);
      reg_rd(6'h1D, 8'h91);
      for (int i = 0; i < 8; i++) begin
         while (m_settle != 0 || m_cnt != 0) sample(goals[amplitude_goal_in]);
         cfg = 8'($urandom());
         cfg[3:2] = 2'(i);
         reg_wr_rd(cfg);
         check("hyst", {6'h0, deviation_hysteresis_sel_out}, {6'h0, cfg[7:6]});
         check("ook", {3'h0, ook_boundary_db_out}, 8'((cfg[1:0] + 1) * 4));
         @(posedge clk_in) rx_restart_in <= 1;
         ook_mode_in <= 1'($urandom());
         amplitude_goal_in <= 3'($urandom());
         @(posedge clk_in) rx_restart_in <= 0;
         m_sync = 0;
         for (int b = 0; b < 6; b++) begin
            if (b == 3) begin
               @(posedge clk_in) sync_found_in <= 1;
               @(posedge clk_in) sync_found_in <= 0;
               m_sync = 1;
            end
            lvl = goals[amplitude_goal_in] + int'($urandom_range(40)) - 20;
            repeat (40) sample(lvl + int'($urandom_range(2)));
         end
      end
      end_sim();
   end
endmodule
